// ### rtl/wcf_pkg.sv
// Purpose: Shared constants and types for the word compare flag unit
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes: Byte offsets are the addresses seen on haddr[7:0]

package wcf_pkg;

  // ==========================================================
  // Data widths
  localparam int unsigned WORD_W = 16; // One controller word
  localparam int unsigned DBL_W = 32; // Two-word operand
  localparam int unsigned TBL_N = 16; // Entries in the table compare
  localparam int unsigned TBL_IDX_W = 4; // Index width into the table
  localparam int unsigned ADDR_W = 8; // Decoded address bits

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_OPA_LO = 8'h00; // First operand, low word
  localparam logic [7:0] OFS_OPA_HI = 8'h04; // First operand, high word
  localparam logic [7:0] OFS_OPB_LO = 8'h08; // Second operand, low word
  localparam logic [7:0] OFS_OPB_HI = 8'h0C; // Second operand, high word
  localparam logic [7:0] OFS_CMD = 8'h10; // Command, write starts
  localparam logic [7:0] OFS_FLAGS = 8'h14; // Condition flags and busy
  localparam logic [7:0] OFS_RESULT = 8'h18; // Table match word
  localparam logic [7:0] OFS_INWORD = 8'h1C; // Last sampled input word
  localparam logic [7:0] OFS_TBL_BASE = 8'h40; // Table words 0..15
  localparam logic [7:0] OFS_TBL_END = 8'h7C; // Last table word

  // ==========================================================
  // Command fields
  localparam int unsigned CMD_OP_LSB = 0; // Operation select
  localparam int unsigned CMD_REF_A_BIT = 4; // Refresh first operand
  localparam int unsigned CMD_REF_B_BIT = 5; // Refresh second operand

  // ==========================================================
  // Flag bit positions
  localparam int unsigned FLG_GT = 0;
  localparam int unsigned FLG_GE = 1;
  localparam int unsigned FLG_EQ = 2;
  localparam int unsigned FLG_LE = 3;
  localparam int unsigned FLG_LT = 4;
  localparam int unsigned FLG_NE = 5;
  localparam int unsigned FLG_ER = 6;
  localparam int unsigned FLG_NEG = 7;
  localparam int unsigned FLG_BUSY = 8;
  localparam logic [7:0] FLAGS_RST = 8'h00; // All flags OFF after reset
  localparam logic [15:0] WORD_RST = 16'h0000; // Data words after reset

  // ==========================================================
  // Bus constants
  localparam int unsigned HTRANS_ACT_BIT = 1; // NONSEQ or SEQ
  localparam logic HRESP_OKAY = 1'b0;

  // Operations
  typedef enum logic [2:0] {
    WCF_OP_UWORD = 3'h0,
    WCF_OP_UDBL = 3'h1,
    WCF_OP_SWORD = 3'h2,
    WCF_OP_SDBL = 3'h3,
    WCF_OP_TABLE = 3'h4
  } wcf_op_e;

  // Sequencer states, Gray along idle-load-exec
  typedef enum logic [1:0] {
    WCF_ST_IDLE = 2'b00,
    WCF_ST_LOAD = 2'b01,
    WCF_ST_EXEC = 2'b11
  } wcf_state_e;

endpackage

// ### rtl/wcf_relate.sv
// Purpose: Magnitude relation of two operands, word or double, signed or not
// Assumes: Pure combinational, operands already assembled
// Notes: Word mode looks only at the low halves

`timescale 1ns/100ps

module wcf_relate (
  input wire logic [31:0] a,
  input wire logic [31:0] b,
  input wire logic signed_mode,
  input wire logic double_mode,
  output logic gt,
  output logic eq,
  output logic lt
);

  // ==========================================================
  // Operand extension
  // One extra bit lets a single signed compare serve all four modes
  logic [32:0] a_ext; // Extended first operand
  logic [32:0] b_ext; // Extended second operand
  logic a_top; // Sign bit of first, or zero
  logic b_top; // Sign bit of second, or zero

  assign a_top = signed_mode & (double_mode ? a[31] : a[15]);
  assign b_top = signed_mode & (double_mode ? b[31] : b[15]);
  assign a_ext = double_mode ? {a_top, a} : {{17{a_top}}, a[15:0]};
  assign b_ext = double_mode ? {b_top, b} : {{17{b_top}}, b[15:0]};

  // ==========================================================
  // Relation, exactly one of three is set
  assign eq = (a_ext == b_ext);
  assign lt = ($signed(a_ext) < $signed(b_ext));
  assign gt = ~eq & ~lt;

endmodule

// ### rtl/wcf_top.sv
// Purpose: Word compare flag unit with AHB-Lite register access
// Assumes: Sequencer writes operands then the command, then reads flags
// Notes: Zero wait states; a command written while busy is dropped
//
// Behaviour
// - Single unsigned compare treats words unsigned
// - Double unsigned compare uses 32-bit values
// - Lower word is the less significant half
// - Single signed compare uses two's complement
// - Double signed compare uses signed 32 bits
// - Six flags follow the relation exactly
// - Equal operands drive the equal flag ON
// - Flags hold the result at completion
// - Refresh variant samples input word first
// - Table compare builds sixteen-bit match word
// - Bit n set when entry n matches
// - Table: equal iff result zero, error cleared

`timescale 1ns/100ps

module wcf_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [15:0] builtin_in,
  output logic greater_flag,
  output logic greater_or_equal_flag,
  output logic equal_flag,
  output logic less_or_equal_flag,
  output logic less_flag,
  output logic not_equal_flag,
  output logic error_flag,
  output logic negative_flag,
  output logic busy,
  output logic done
);

  // ==========================================================
  // Bus address phase capture
  logic ap_valid_ff; // Data phase in progress
  logic ap_write_ff; // Data phase is a write
  logic [7:0] ap_addr_ff; // Captured byte address
  logic ap_take; // Address phase accepted

  assign ap_take = hsel & htrans[wcf_pkg::HTRANS_ACT_BIT] & hready;
  assign hreadyout = 1'b1; // Every access ends in one data cycle
  assign hresp = wcf_pkg::HRESP_OKAY;

  // Capture address phase; hsize ignored, only whole words supported
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_ff <= 1'b0;
      ap_write_ff <= 1'b0;
      ap_addr_ff <= 8'h00;
    end else begin
      ap_valid_ff <= ap_take;
      ap_write_ff <= hwrite;
      ap_addr_ff <= haddr[7:0];
    end
  end

  // Table decode, used by both write and read paths
  function automatic logic is_tbl(input logic [7:0] addr);
    is_tbl = (addr >= wcf_pkg::OFS_TBL_BASE) && (addr <= wcf_pkg::OFS_TBL_END) &&
      (addr[1:0] == 2'b00);
  endfunction

  // ==========================================================
  // Write strobes
  logic wr_en; // Write data phase
  logic wr_opa_lo, wr_opa_hi, wr_opb_lo, wr_opb_hi, wr_cmd, wr_flags, wr_tbl;
  logic [3:0] tbl_idx; // Table entry addressed

  assign wr_en = ap_valid_ff & ap_write_ff;
  assign wr_opa_lo = wr_en && (ap_addr_ff == wcf_pkg::OFS_OPA_LO);
  assign wr_opa_hi = wr_en && (ap_addr_ff == wcf_pkg::OFS_OPA_HI);
  assign wr_opb_lo = wr_en && (ap_addr_ff == wcf_pkg::OFS_OPB_LO);
  assign wr_opb_hi = wr_en && (ap_addr_ff == wcf_pkg::OFS_OPB_HI);
  assign wr_cmd = wr_en && (ap_addr_ff == wcf_pkg::OFS_CMD);
  assign wr_flags = wr_en && (ap_addr_ff == wcf_pkg::OFS_FLAGS);
  assign wr_tbl = wr_en && is_tbl(ap_addr_ff);
  assign tbl_idx = ap_addr_ff[5:2];

  // ==========================================================
  // Operand and table storage
  logic [15:0] opa_lo_ff, opa_hi_ff, opb_lo_ff, opb_hi_ff; // Operand words
  logic [15:0] tbl_ff [wcf_pkg::TBL_N]; // Table words

  // Operand words written by software only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      opa_lo_ff <= wcf_pkg::WORD_RST;
      opa_hi_ff <= wcf_pkg::WORD_RST;
      opb_lo_ff <= wcf_pkg::WORD_RST;
      opb_hi_ff <= wcf_pkg::WORD_RST;
    end else begin
      if (wr_opa_lo) opa_lo_ff <= hwdata[15:0];
      if (wr_opa_hi) opa_hi_ff <= hwdata[15:0];
      if (wr_opb_lo) opb_lo_ff <= hwdata[15:0];
      if (wr_opb_hi) opb_hi_ff <= hwdata[15:0];
    end
  end

  // Table words; reset costs area but keeps reads defined
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < wcf_pkg::TBL_N; i++) begin
        tbl_ff[i] <= wcf_pkg::WORD_RST;
      end
    end else if (wr_tbl) begin
      tbl_ff[tbl_idx] <= hwdata[15:0];
    end
  end

  // ==========================================================
  // Command sequencer
  wcf_pkg::wcf_state_e state_ff, nxt_state;
  wcf_pkg::wcf_op_e op_ff; // Latched operation
  logic ref_a_ff, ref_b_ff; // Latched refresh selects
  logic [15:0] in_word_ff; // Freshly sampled built-in input
  logic start; // Command accepted
  logic done_ff; // Completion pulse
  logic exec; // Result written this cycle

  assign start = wr_cmd && (state_ff == wcf_pkg::WCF_ST_IDLE);
  assign exec = (state_ff == wcf_pkg::WCF_ST_EXEC);

  // Idle, then sample input, then write flags
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      wcf_pkg::WCF_ST_IDLE: if (start) nxt_state = wcf_pkg::WCF_ST_LOAD;
      wcf_pkg::WCF_ST_LOAD: nxt_state = wcf_pkg::WCF_ST_EXEC;
      wcf_pkg::WCF_ST_EXEC: nxt_state = wcf_pkg::WCF_ST_IDLE;
      default: nxt_state = wcf_pkg::WCF_ST_IDLE; // Code 2'b10 unused
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= wcf_pkg::WCF_ST_IDLE;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      done_ff <= exec;
    end
  end

  // Latch the command; an undefined op code falls back to word compare
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_ff <= wcf_pkg::WCF_OP_UWORD;
      ref_a_ff <= 1'b0;
      ref_b_ff <= 1'b0;
    end else if (start) begin
      op_ff <= (hwdata[2:0] > 3'h4) ? wcf_pkg::WCF_OP_UWORD :
        wcf_pkg::wcf_op_e'(hwdata[2:0]);
      ref_a_ff <= hwdata[wcf_pkg::CMD_REF_A_BIT];
      ref_b_ff <= hwdata[wcf_pkg::CMD_REF_B_BIT];
    end
  end

  // Input word is re-read just before the compare runs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_word_ff <= wcf_pkg::WORD_RST;
    end else if (state_ff == wcf_pkg::WCF_ST_LOAD) begin
      in_word_ff <= builtin_in;
    end
  end

  // ==========================================================
  // Datapath
  logic [15:0] a_lo, b_lo; // Low words after refresh select
  logic [31:0] a_full, b_full; // Assembled operands
  logic is_signed, is_double, is_table;
  logic rel_gt, rel_eq, rel_lt;
  logic [15:0] match; // Table match word
  logic [15:0] result_ff; // Stored match word

  assign a_lo = ref_a_ff ? in_word_ff : opa_lo_ff;
  assign b_lo = ref_b_ff ? in_word_ff : opb_lo_ff;
  assign a_full = {opa_hi_ff, a_lo};
  assign b_full = {opb_hi_ff, b_lo};
  assign is_signed = (op_ff == wcf_pkg::WCF_OP_SWORD) || (op_ff == wcf_pkg::WCF_OP_SDBL);
  assign is_double = (op_ff == wcf_pkg::WCF_OP_UDBL) || (op_ff == wcf_pkg::WCF_OP_SDBL);
  assign is_table = (op_ff == wcf_pkg::WCF_OP_TABLE);

  // Relation per mode
  wcf_relate u_relate (
    .a(a_full),
    .b(b_full),
    .signed_mode(is_signed),
    .double_mode(is_double),
    .gt(rel_gt),
    .eq(rel_eq),
    .lt(rel_lt)
  );

  // One comparator per table entry, source is the first operand low word
  generate
    for (genvar n = 0; n < wcf_pkg::TBL_N; n++) begin : g_match
      assign match[n] = (tbl_ff[n] == a_lo);
    end
  endgenerate

  // ==========================================================
  // Flags
  logic [7:0] flags_ff, nxt_flags, cmp_flags, tbl_flags;

  // Six relation flags; error and negative carried through
  assign cmp_flags = {flags_ff[wcf_pkg::FLG_NEG], flags_ff[wcf_pkg::FLG_ER], ~rel_eq,
    rel_lt, rel_lt | rel_eq, rel_eq, rel_gt | rel_eq, rel_gt};
  // Table: equal from an all-zero match word, error cleared
  assign tbl_flags = {flags_ff[wcf_pkg::FLG_NEG], 1'b0, flags_ff[5:3], (match == 16'h0000),
    flags_ff[1:0]};
  // Software may set error and negative, as other flag writers would
  assign nxt_flags = exec ? (is_table ? tbl_flags : cmp_flags) :
    wr_flags ? {hwdata[7:6], flags_ff[5:0]} : flags_ff;

  // Compare result wins over a same-cycle software write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_ff <= wcf_pkg::FLAGS_RST;
      result_ff <= wcf_pkg::WORD_RST;
    end else begin
      flags_ff <= nxt_flags;
      if (exec && is_table) result_ff <= match;
    end
  end

  assign greater_flag = flags_ff[wcf_pkg::FLG_GT];
  assign greater_or_equal_flag = flags_ff[wcf_pkg::FLG_GE];
  assign equal_flag = flags_ff[wcf_pkg::FLG_EQ];
  assign less_or_equal_flag = flags_ff[wcf_pkg::FLG_LE];
  assign less_flag = flags_ff[wcf_pkg::FLG_LT];
  assign not_equal_flag = flags_ff[wcf_pkg::FLG_NE];
  assign error_flag = flags_ff[wcf_pkg::FLG_ER];
  assign negative_flag = flags_ff[wcf_pkg::FLG_NEG];
  assign busy = (state_ff != wcf_pkg::WCF_ST_IDLE);
  assign done = done_ff;

  // ==========================================================
  // Read mux, combinational from registers so a read sees a prior write
  logic [15:0] rd_word; // Selected register
  logic [15:0] rd_tbl; // Selected table entry
  logic [15:0] rd_cmd; // Command readback

  assign rd_tbl = tbl_ff[tbl_idx];
  assign rd_cmd = {10'h000, ref_b_ff, ref_a_ff, 1'b0, op_ff};
  assign rd_word =
    (ap_addr_ff == wcf_pkg::OFS_OPA_LO) ? opa_lo_ff :
    (ap_addr_ff == wcf_pkg::OFS_OPA_HI) ? opa_hi_ff :
    (ap_addr_ff == wcf_pkg::OFS_OPB_LO) ? opb_lo_ff :
    (ap_addr_ff == wcf_pkg::OFS_OPB_HI) ? opb_hi_ff :
    (ap_addr_ff == wcf_pkg::OFS_CMD) ? rd_cmd :
    (ap_addr_ff == wcf_pkg::OFS_FLAGS) ? {7'h00, busy, flags_ff} :
    (ap_addr_ff == wcf_pkg::OFS_RESULT) ? result_ff :
    (ap_addr_ff == wcf_pkg::OFS_INWORD) ? in_word_ff :
    is_tbl(ap_addr_ff) ? rd_tbl : 16'h0000;
  assign hrdata = (ap_valid_ff && !ap_write_ff) ? {16'h0000, rd_word} : 32'h0000_0000;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic cmp_exec; // A non-table compare completes
  assign cmp_exec = exec && !is_table;

  uword_flags_a: assert property (
    cmp_exec && (op_ff == wcf_pkg::WCF_OP_UWORD) |=>
      greater_flag == ($past(a_lo) > $past(b_lo)) && less_flag == ($past(a_lo) < $past(b_lo)))
    else $error("unsigned word compare flags wrong");
  udbl_flags_a: assert property (
    cmp_exec && (op_ff == wcf_pkg::WCF_OP_UDBL) |=>
      greater_flag == ($past(a_full) > $past(b_full)))
    else $error("unsigned double compare flags wrong");
  dbl_order_a: assert property (
    cmp_exec && is_double && (opa_hi_ff != opb_hi_ff) |=>
      equal_flag == 1'b0)
    else $error("high word ignored in double compare");
  sword_flags_a: assert property (
    cmp_exec && (op_ff == wcf_pkg::WCF_OP_SWORD) |=>
      less_flag == ($signed($past(a_lo)) < $signed($past(b_lo))))
    else $error("signed word compare flags wrong");
  sdbl_flags_a: assert property (
    cmp_exec && (op_ff == wcf_pkg::WCF_OP_SDBL) |=>
      less_flag == ($signed($past(a_full)) < $signed($past(b_full))))
    else $error("signed double compare flags wrong");

  flag_set_a: assert property (
    cmp_exec |=> (greater_flag + equal_flag + less_flag == 2'd1) &&
      greater_or_equal_flag == (greater_flag | equal_flag) &&
      less_or_equal_flag == (less_flag | equal_flag) && not_equal_flag == !equal_flag)
    else $error("flag set inconsistent");

  equal_on_a: assert property (
    cmp_exec && (a_full == b_full) |=> equal_flag)
    else $error("equal operands without equal flag");

  cmd_timing_a: assert property (
    start |=> busy ##1 busy ##1 (!busy && done))
    else $error("compare not complete three cycles after command");

  refresh_a: assert property (
    state_ff == wcf_pkg::WCF_ST_LOAD |=> in_word_ff == $past(builtin_in))
    else $error("input word not refreshed");

  tbl_bits_a: assert property (
    exec && is_table |=> result_ff == $past(match) &&
      result_ff[0] == ($past(tbl_ff[0]) == $past(a_lo)))
    else $error("table match word wrong");

  tbl_flags_a: assert property (
    exec && is_table |=> !error_flag && equal_flag == (result_ff == 16'h0000))
    else $error("table compare flags wrong");

  keep_er_a: assert property (
    cmp_exec && !wr_flags |=> $stable(error_flag) && $stable(negative_flag))
    else $error("error or negative flag changed by compare");

  tbl_run_c: cover property (start ##2 (exec && is_table));
  sdbl_lt_c: cover property (cmp_exec && (op_ff == wcf_pkg::WCF_OP_SDBL) ##1 less_flag);
  refresh_c: cover property (cmp_exec && ref_a_ff ##1 equal_flag);
  busy_drop_c: cover property (busy && wr_cmd);

endmodule

// ### tb/wcf_seq_model.sv
// Purpose: Sequencer model, AHB-Lite master and built-in input source
// Assumes: One slave, so hreadyout is the bus ready
// Notes: Released lines show inverted values so stale data is never trusted

`timescale 1ns/100ps

module wcf_seq_model (
  input wire logic hclk,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic [15:0] builtin_in
);
  // ==========================================================
  // Idle bus at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    builtin_in = 16'h0000;
  end

  // ==========================================================
  // Single word transfer; ops run strictly one after another
  task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    hwdata <= ~hwdata;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    // Address released: show its inverse
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= ~{24'h000000, a};
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask

  // New built-in input level, changed between commands only
  task automatic set_in(input logic [15:0] v);
    builtin_in <= v;
  endtask
endmodule

// ### tb/word_compare_flag_unit_tb.sv
// Purpose: Self-checking bench for the compare flag unit
// Assumes: Zero wait state slave, command runs two busy cycles
// Notes: Seeded random operands with sign and equality corners mixed in

`timescale 1ns/100ps

module word_compare_flag_unit_tb;
  // ==========================================================
  // Signals
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q, a, b, ea, eb;
  logic [1:0] htrans;
  logic [2:0] hsize, op;
  logic [15:0] inw, src, res, tbl [16];
  logic [15:0] builtin_in; // Input word on the pins, driven by the model
  logic greater_flag, greater_or_equal_flag, equal_flag, less_or_equal_flag;
  logic less_flag, not_equal_flag, error_flag, negative_flag, busy, done;
  logic [7:0] flg, exp_flg;
  logic ra, rb, er, ng;
  int err_total, n_tests, seed, cyc;
  assign flg = {negative_flag, error_flag, not_equal_flag, less_flag, less_or_equal_flag,
                equal_flag, greater_or_equal_flag, greater_flag};

  wcf_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .builtin_in(builtin_in),
    .greater_flag(greater_flag), .greater_or_equal_flag(greater_or_equal_flag),
    .equal_flag(equal_flag), .less_or_equal_flag(less_or_equal_flag),
    .less_flag(less_flag), .not_equal_flag(not_equal_flag), .error_flag(error_flag),
    .negative_flag(negative_flag), .busy(busy), .done(done));
  wcf_seq_model seq_u (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .builtin_in(builtin_in));

  // ==========================================================
  // Clock and hang guard
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial cyc = 0;
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    // Far above the roughly two thousand cycles the sequence needs
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end

  // ==========================================================
  // Helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("Counts: %0d mismatches in %0d compares", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    seq_u.bus_xfer(1'b1, ad, d, q);
  endtask

  // Relation bits {ne, lt, le, eq, ge, gt}; double ops take hi word as upper half
  function automatic logic [5:0] rel(input logic [2:0] o, input logic [31:0] x,
                                     input logic [31:0] y);
    logic g;
    logic e;
    e = (o == 3'h1 || o == 3'h3) ? (x == y) : (x[15:0] == y[15:0]);
    case (o)
      3'h1: g = x > y;
      3'h2: g = $signed(x[15:0]) > $signed(y[15:0]);
      3'h3: g = $signed(x) > $signed(y);
      default: g = x[15:0] > y[15:0];
    endcase
    rel = {!e, !g && !e, !g, e, g || e, g};
  endfunction

  // Preset error and negative, issue the command, follow its fixed timing
  task automatic run_cmd(input logic [2:0] o);
    wr(wcf_pkg::OFS_FLAGS, {24'h000000, ng, er, 6'h00});
    wr(wcf_pkg::OFS_CMD, {26'h0000000, rb, ra, 1'b0, o});
    @(negedge hclk);
    chk(busy, 1'b1);
    @(negedge hclk);
    chk(busy, 1'b1);
    @(negedge hclk);
    chk(done, 1'b1);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    err_total = 0;
    n_tests = 0;
    seed = 64;
    exp_flg = 8'h00;
    hresetn = 1'b0;
    repeat (12) @(posedge hclk);
    @(negedge hclk);
    chk({hreadyout, hresp, busy, done, flg}, 32'h800);
    chk(hrdata, 32'h0);
    // Release on a rising edge, like every other input
    @(posedge hclk);
    hresetn <= 1'b1;
    // Random word and double compares, codes above 4 included
    for (int i = 0; i < 60; i++) begin
      a = $random(seed);
      b = $random(seed);
      if (i % 4 == 0) b = a;
      if (i % 4 == 1) b = {a[31:16], a[15:0] ^ 16'h8000};
      if (i % 4 == 2) b = a ^ 32'h80000000;
      op = (i < 8) ? i[2:0] : 3'({$random(seed)} % 8);
      if (op == 3'h4) op = 3'h0;
      {ra, rb, er, ng} = 4'($random(seed));
      inw = 16'($random(seed));
      seq_u.set_in(inw);
      wr(wcf_pkg::OFS_OPA_LO, {16'h0000, a[15:0]});
      wr(wcf_pkg::OFS_OPA_HI, {16'h0000, a[31:16]});
      wr(wcf_pkg::OFS_OPB_LO, {16'h0000, b[15:0]});
      wr(wcf_pkg::OFS_OPB_HI, {16'h0000, b[31:16]});
      run_cmd(op);
      ea = {a[31:16], ra ? inw : a[15:0]};
      eb = {b[31:16], rb ? inw : b[15:0]};
      exp_flg = {ng, er, rel(op, ea, eb)};
      chk(flg, exp_flg);
      seq_u.bus_xfer(1'b0, wcf_pkg::OFS_FLAGS, 32'h0, q);
      chk(q, {24'h000000, exp_flg});
      seq_u.bus_xfer(1'b0, wcf_pkg::OFS_INWORD, 32'h0, q);
      chk(q, {16'h0000, inw});
    end
    // Table compare: no match, then matches at both ends
    for (int t = 0; t < 4; t++) begin
      src = 16'($random(seed));
      res = 16'h0000;
      for (int n = 0; n < 16; n++) begin
        tbl[n] = (t > 0 && (n == 0 || n == 15 || $random(seed) % 3 == 0)) ? src : ~src;
        res[n] = (tbl[n] == src);
        wr(8'(wcf_pkg::OFS_TBL_BASE + 4 * n), {16'h0000, tbl[n]});
      end
      {ra, rb, er, ng} = {1'b0, 1'b0, 1'b1, t[0]};
      wr(wcf_pkg::OFS_OPA_LO, {16'h0000, src});
      run_cmd(3'h4);
      exp_flg = {ng, 1'b0, exp_flg[5:3], res == 16'h0000, exp_flg[1:0]};
      chk(flg, exp_flg);
      seq_u.bus_xfer(1'b0, wcf_pkg::OFS_RESULT, 32'h0, q);
      chk(q, {16'h0000, res});
    end
    // Read-only result and an unmapped place
    wr(wcf_pkg::OFS_RESULT, 32'h0000FFFF);
    seq_u.bus_xfer(1'b0, wcf_pkg::OFS_RESULT, 32'h0, q);
    chk(q, {16'h0000, res});
    seq_u.bus_xfer(1'b0, 8'h30, 32'h0, q);
    chk(q, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    test_done();
  end
endmodule
